/* File: sul_pkg.sv */
// Constants and carrier types for the sensor start-up upload controller.
package sul_pkg;
  // Own AHB-Lite registers, byte offsets.
  localparam logic [7:0] REG_CTRL = 8'h00;
  localparam logic [7:0] REG_STATUS = 8'h04;
  localparam logic [7:0] REG_STEP = 8'h08;
  localparam logic [7:0] REG_RDATA = 8'h0c;
  localparam int CTRL_START_BIT = 0;
  localparam int CTRL_COLOR_BIT = 1;
  localparam int CTRL_DEPTH8_BIT = 2;
  localparam logic CTRL_COLOR_RST = 1'b0;
  localparam logic CTRL_DEPTH8_RST = 1'b0;
  localparam int STAT_BUSY_BIT = 0;
  localparam int STAT_DONE_BIT = 1;
  localparam int STAT_PHASE_LSB = 4;
  // Timing.
  localparam int CLK_PERIOD_NS = 100;
  localparam int CLK_SETUP_NS = 1000;
  localparam int CLK_SETUP_CYC = (CLK_SETUP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int RST_SETTLE_NS = 10000;
  localparam int RST_SETTLE_CYC = (RST_SETTLE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int SPI_HALF_CYC = 4;
  localparam int FRAME_BITS = 26;
  // Upload program layout.
  localparam logic [4:0] N_STEPS = 5'h14;
  localparam logic [4:0] PH_UPLOAD_FIRST = 5'h03;
  localparam logic [4:0] PH_POWER_FIRST = 5'h0e;
  localparam logic [4:0] PH_SEQ_FIRST = 5'h13;
  // Sensor register addresses.
  localparam logic [8:0] SNS_VARIANT = 9'h002;
  localparam logic [8:0] SNS_CLK_CFG = 9'h020;
  localparam logic [8:0] SNS_LOGIC_EN = 9'h022;
  localparam logic [8:0] SNS_COLMUX = 9'h028;
  localparam logic [8:0] SNS_AFE = 9'h030;
  localparam logic [8:0] SNS_BIAS_EN = 9'h040;
  localparam logic [8:0] SNS_BIAS_GEN = 9'h041;
  localparam logic [8:0] SNS_BIAS_AFE = 9'h042;
  localparam logic [8:0] SNS_BIAS_MUX = 9'h043;
  localparam logic [8:0] SNS_BIAS_LINK = 9'h044;
  localparam logic [8:0] SNS_LINK_TX = 9'h070;
  localparam logic [8:0] SNS_BLACK_CAL = 9'h080;
  localparam logic [8:0] SNS_DEPTH = 9'h081;
  localparam logic [8:0] SNS_SEQ_MODE = 9'h0c0;
  localparam logic [8:0] SNS_GAIN = 9'h0cc;
  localparam logic [8:0] SNS_DUMMY_ROWS = 9'h0e0;
  localparam logic [8:0] SNS_LATENCY = 9'h0e1;
  localparam logic [8:0] SNS_SEQ_CFG_A = 9'h1bf;
  localparam logic [8:0] SNS_SEQ_CFG_B = 9'h1c0;
  // Sensor register values.
  localparam logic [15:0] V_CLK_LOGIC = 16'h2002;
  localparam logic [15:0] V_CLK_ANALOG = 16'h2003;
  localparam logic [15:0] V_ON = 16'h0001;
  localparam logic [15:0] V_COLMUX_ON = 16'h0003;
  localparam logic [15:0] V_LINK_TX_ON = 16'h0007;
  localparam logic [15:0] V_BIAS_GEN = 16'h008b;
  localparam logic [15:0] V_BIAS_AFE = 16'h53c6;
  localparam logic [15:0] V_BIAS_MUX = 16'h0844;
  localparam logic [15:0] V_BIAS_LINK = 16'h0086;
  localparam logic [15:0] V_BLACK_CAL = 16'h4520;
  localparam logic [15:0] V_GAIN = 16'h09e5;
  localparam logic [15:0] V_DUMMY_ROWS = 16'h3e04;
  localparam logic [15:0] V_LATENCY = 16'h6733;
  localparam logic [15:0] V_SEQ_CFG_A = 16'h0bf1;
  localparam logic [15:0] V_SEQ_CFG_B = 16'h0bc3;
  localparam logic [15:0] M_DEPTH8 = 16'h2000;
  localparam logic [15:0] M_SEQ_EN = 16'h0001;
  localparam logic [15:0] M_NONE = 16'h0000;

  typedef struct packed {
    logic [8:0] addr;
    logic wr;
    logic [15:0] data;
  } sul_frame_t;

  typedef struct packed {
    logic [8:0] addr;
    logic [15:0] data;
    logic [15:0] mask;
  } sul_entry_t;
endpackage

/* File: sul_ctrl.sv */
// Host controller that powers up the sensor and runs its start-up upload program.
//
// Local design decision: the AHB-Lite slave port.
`timescale 1ns/1ps
module sul_ctrl (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic [31:0] hrdata,
  output logic hresp,
  output logic sensor_clk_en,
  output logic sensor_rst_n,
  output logic spi_sclk,
  output logic spi_mosi,
  output logic spi_ssel_n,
  input wire logic spi_miso
);
  typedef enum logic [7:0] {
    ST_IDLE = 8'b00000001,
    ST_CLK = 8'b00000010,
    ST_SETTLE = 8'b00000100,
    ST_ISSUE = 8'b00001000,
    ST_RD = 8'b00010000,
    ST_MOD = 8'b00100000,
    ST_WR = 8'b01000000,
    ST_DONE = 8'b10000000
  } sul_state_t;

  sul_state_t state_q;
  logic color_q, depth8_q, start_q;
  logic wr_pend_q;
  logic [7:0] wr_addr_q;
  logic [31:0] hrdata_q;
  logic hreadyout_q, hresp_q;
  logic clk_en_q, rst_n_q;
  logic [7:0] wait_q;
  logic [4:0] step_q;
  logic [15:0] rmw_q;
  logic done_flag_q;
  logic miso_m_q, miso_s_q;
  logic active_q, sclk_q, mosi_q, ssel_n_q, spi_done_q;
  logic [2:0] div_q;
  logic [4:0] bit_q;
  logic [25:0] shift_q;
  logic [15:0] rx_q;
  logic xfer_go;
  sul_pkg::sul_frame_t xfer_frame;
  sul_pkg::sul_entry_t ent;
  logic addr_ok;

  // The program; variant and depth are taken from the control register when issued.
  function automatic sul_pkg::sul_entry_t prog(input logic [4:0] i, input logic col,
                                               input logic d8);
    sul_pkg::sul_entry_t e;
    e = '{sul_pkg::SNS_VARIANT, {15'h0000, col}, sul_pkg::M_NONE};
    case (i)
      5'h00: e = '{sul_pkg::SNS_VARIANT, {15'h0000, col}, sul_pkg::M_NONE};
      5'h01: e = '{sul_pkg::SNS_CLK_CFG, sul_pkg::V_CLK_LOGIC, sul_pkg::M_NONE};
      5'h02: e = '{sul_pkg::SNS_LOGIC_EN, sul_pkg::V_ON, sul_pkg::M_NONE};
      5'h03: e = '{sul_pkg::SNS_BIAS_GEN, sul_pkg::V_BIAS_GEN, sul_pkg::M_NONE};
      5'h04: e = '{sul_pkg::SNS_BIAS_AFE, sul_pkg::V_BIAS_AFE, sul_pkg::M_NONE};
      5'h05: e = '{sul_pkg::SNS_BIAS_MUX, sul_pkg::V_BIAS_MUX, sul_pkg::M_NONE};
      5'h06: e = '{sul_pkg::SNS_BIAS_LINK, sul_pkg::V_BIAS_LINK, sul_pkg::M_NONE};
      5'h07: e = '{sul_pkg::SNS_BLACK_CAL, sul_pkg::V_BLACK_CAL, sul_pkg::M_NONE};
      5'h08: e = '{sul_pkg::SNS_GAIN, sul_pkg::V_GAIN, sul_pkg::M_NONE};
      5'h09: e = '{sul_pkg::SNS_DUMMY_ROWS, sul_pkg::V_DUMMY_ROWS, sul_pkg::M_NONE};
      5'h0a: e = '{sul_pkg::SNS_LATENCY, sul_pkg::V_LATENCY, sul_pkg::M_NONE};
      5'h0b: e = '{sul_pkg::SNS_DEPTH, (d8 ? sul_pkg::M_DEPTH8 : 16'h0000),
                   sul_pkg::M_DEPTH8};
      5'h0c: e = '{sul_pkg::SNS_SEQ_CFG_A, sul_pkg::V_SEQ_CFG_A, sul_pkg::M_NONE};
      5'h0d: e = '{sul_pkg::SNS_SEQ_CFG_B, sul_pkg::V_SEQ_CFG_B, sul_pkg::M_NONE};
      5'h0e: e = '{sul_pkg::SNS_CLK_CFG, sul_pkg::V_CLK_ANALOG, sul_pkg::M_NONE};
      5'h0f: e = '{sul_pkg::SNS_BIAS_EN, sul_pkg::V_ON, sul_pkg::M_NONE};
      5'h10: e = '{sul_pkg::SNS_COLMUX, sul_pkg::V_COLMUX_ON, sul_pkg::M_NONE};
      5'h11: e = '{sul_pkg::SNS_AFE, sul_pkg::V_ON, sul_pkg::M_NONE};
      5'h12: e = '{sul_pkg::SNS_LINK_TX, sul_pkg::V_LINK_TX_ON, sul_pkg::M_NONE};
      5'h13: e = '{sul_pkg::SNS_SEQ_MODE, sul_pkg::M_SEQ_EN, sul_pkg::M_SEQ_EN};
      default: e = '{sul_pkg::SNS_VARIANT, {15'h0000, col}, sul_pkg::M_NONE};
    endcase
    return e;
  endfunction

  function automatic logic [1:0] phase_of(input logic [4:0] i);
    if (i >= sul_pkg::PH_SEQ_FIRST) begin
      return 2'h3;
    end else if (i >= sul_pkg::PH_POWER_FIRST) begin
      return 2'h2;
    end else if (i >= sul_pkg::PH_UPLOAD_FIRST) begin
      return 2'h1;
    end
    return 2'h0;
  endfunction

  assign ent = prog(step_q, color_q, depth8_q);
  assign addr_ok = hsel && htrans[1] && hready;

  // AHB-Lite slave: zero wait states, always OKAY.
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hreadyout_q <= 1'b1;
      hresp_q <= 1'b0;
      wr_pend_q <= 1'b0;
      wr_addr_q <= 8'h00;
      hrdata_q <= 32'h00000000;
    end else begin
      wr_pend_q <= addr_ok && hwrite;
      if (addr_ok) begin
        wr_addr_q <= haddr[7:0];
      end
      if (addr_ok && !hwrite) begin
        case (haddr[7:0])
          sul_pkg::REG_CTRL: hrdata_q <= {29'h00000000, depth8_q, color_q, 1'b0};
          sul_pkg::REG_STATUS: hrdata_q <= {26'h0000000, phase_of(step_q), 2'h0,
                                            done_flag_q, !(state_q inside {ST_IDLE, ST_DONE})};
          sul_pkg::REG_STEP: hrdata_q <= {27'h0000000, step_q};
          sul_pkg::REG_RDATA: hrdata_q <= {16'h0000, rx_q};
          default: hrdata_q <= 32'h00000000;
        endcase
      end
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      color_q <= sul_pkg::CTRL_COLOR_RST;
      depth8_q <= sul_pkg::CTRL_DEPTH8_RST;
      start_q <= 1'b0;
    end else begin
      start_q <= 1'b0;
      if (wr_pend_q && wr_addr_q == sul_pkg::REG_CTRL) begin
        color_q <= hwdata[sul_pkg::CTRL_COLOR_BIT];
        depth8_q <= hwdata[sul_pkg::CTRL_DEPTH8_BIT];
        start_q <= hwdata[sul_pkg::CTRL_START_BIT];
      end
    end
  end

  // Sequencing of pins and uploads.
  always_comb begin
    xfer_go = 1'b0;
    xfer_frame = '{ent.addr, 1'b1, ent.data};
    if (state_q == ST_ISSUE) begin
      xfer_go = 1'b1;
      xfer_frame = '{ent.addr, (ent.mask == sul_pkg::M_NONE), ent.data};
    end else if (state_q == ST_MOD) begin
      xfer_go = 1'b1;
      xfer_frame = '{ent.addr, 1'b1, rmw_q};
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      state_q <= ST_IDLE;
      clk_en_q <= 1'b0;
      rst_n_q <= 1'b0;
      wait_q <= 8'h00;
      step_q <= 5'h00;
      rmw_q <= 16'h0000;
      done_flag_q <= 1'b0;
    end else begin
      case (state_q)
        ST_IDLE, ST_DONE: begin
          if (start_q) begin
            clk_en_q <= 1'b1;
            rst_n_q <= 1'b0;
            wait_q <= 8'h00;
            done_flag_q <= 1'b0;
            state_q <= ST_CLK;
          end
        end
        ST_CLK: begin
          wait_q <= wait_q + 8'h01;
          if (wait_q == 8'(sul_pkg::CLK_SETUP_CYC - 1)) begin
            rst_n_q <= 1'b1;
            wait_q <= 8'h00;
            state_q <= ST_SETTLE;
          end
        end
        ST_SETTLE: begin
          wait_q <= wait_q + 8'h01;
          if (wait_q == 8'(sul_pkg::RST_SETTLE_CYC - 1)) begin
            step_q <= 5'h00;
            state_q <= ST_ISSUE;
          end
        end
        ST_ISSUE: begin
          state_q <= (ent.mask == sul_pkg::M_NONE) ? ST_WR : ST_RD;
        end
        ST_RD: begin
          if (spi_done_q) begin
            rmw_q <= (rx_q & ~ent.mask) | (ent.data & ent.mask);
            state_q <= ST_MOD;
          end
        end
        ST_MOD: begin
          state_q <= ST_WR;
        end
        ST_WR: begin
          if (spi_done_q) begin
            if (step_q == sul_pkg::N_STEPS - 5'h01) begin
              done_flag_q <= 1'b1;
              state_q <= ST_DONE;
            end else begin
              step_q <= step_q + 5'h01;
              state_q <= ST_ISSUE;
            end
          end
        end
        default: state_q <= ST_IDLE;
      endcase
    end
  end

  // The sensor drives its answer from a foreign clock, so it is synchronised first.
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      miso_m_q <= 1'b0;
      miso_s_q <= 1'b0;
    end else begin
      miso_m_q <= spi_miso;
      miso_s_q <= miso_m_q;
    end
  end

  // Serial engine; the slow clock is a divider enable, so a full bit is eight cycles.
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      active_q <= 1'b0;
      sclk_q <= 1'b0;
      mosi_q <= 1'b0;
      ssel_n_q <= 1'b1;
      spi_done_q <= 1'b0;
      div_q <= 3'h0;
      bit_q <= 5'h00;
      shift_q <= 26'h0000000;
      rx_q <= 16'h0000;
    end else begin
      spi_done_q <= 1'b0;
      if (xfer_go) begin
        active_q <= 1'b1;
        ssel_n_q <= 1'b0;
        sclk_q <= 1'b0;
        shift_q <= xfer_frame;
        mosi_q <= xfer_frame.addr[8];
        bit_q <= 5'h00;
        div_q <= 3'h0;
      end else if (active_q) begin
        div_q <= div_q + 3'h1;
        if (div_q == 3'(sul_pkg::SPI_HALF_CYC - 1)) begin
          div_q <= 3'h0;
          if (!sclk_q) begin
            sclk_q <= 1'b1;
          end else begin
            sclk_q <= 1'b0;
            rx_q <= {rx_q[14:0], miso_s_q};
            shift_q <= {shift_q[24:0], 1'b0};
            mosi_q <= shift_q[24];
            if (bit_q == 5'(sul_pkg::FRAME_BITS - 1)) begin
              active_q <= 1'b0;
              ssel_n_q <= 1'b1;
              mosi_q <= 1'b0;
              spi_done_q <= 1'b1;
            end else begin
              bit_q <= bit_q + 5'h01;
            end
          end
        end
      end
    end
  end

  assign hreadyout = hreadyout_q;
  assign hrdata = hrdata_q;
  assign hresp = hresp_q;
  assign sensor_clk_en = clk_en_q;
  assign sensor_rst_n = rst_n_q;
  assign spi_sclk = sclk_q;
  assign spi_mosi = mosi_q;
  assign spi_ssel_n = ssel_n_q;

  // Helper counters that only the checks read.
  logic [7:0] since_rst_q;
  logic [5:0] edges_q;
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      since_rst_q <= 8'h00;
      edges_q <= 6'h00;
    end else begin
      if (!rst_n_q) begin
        since_rst_q <= 8'h00;
      end else if (since_rst_q != 8'hff) begin
        since_rst_q <= since_rst_q + 8'h01;
      end
      if (xfer_go) begin
        edges_q <= 6'h00;
      end else if (active_q && !sclk_q && div_q == 3'(sul_pkg::SPI_HALF_CYC - 1)) begin
        edges_q <= edges_q + 6'h01;
      end
    end
  end

  sequence s_rst_release;
    !rst_n_q ##1 rst_n_q;
  endsequence

  // The read half of a read-modify-write has just returned its data.
  sequence s_read_done;
    state_q == ST_RD && spi_done_q;
  endsequence

  AST_CLK_BEFORE_RST: assert property (@(posedge hclk) disable iff (!hresetn)
    s_rst_release |-> $past(clk_en_q, 2)) else $error("reset released without clock");
  AST_SETTLE: assert property (@(posedge hclk) disable iff (!hresetn)
    $fell(ssel_n_q) |-> since_rst_q >= 8'(sul_pkg::RST_SETTLE_CYC))
    else $error("write too soon after reset");
  AST_RST_HELD: assert property (@(posedge hclk) disable iff (!hresetn)
    state_q == ST_CLK |-> !rst_n_q) else $error("reset not held during clock start");
  AST_CLK_KEPT: assert property (@(posedge hclk) disable iff (!hresetn)
    state_q inside {ST_SETTLE, ST_ISSUE, ST_RD, ST_MOD, ST_WR} |-> clk_en_q && rst_n_q)
    else $error("sensor clock or reset dropped during the program");
  AST_ONE_XFER: assert property (@(posedge hclk) disable iff (!hresetn)
    xfer_go |-> !active_q && ssel_n_q) else $error("transfer started over another");
  AST_FRAME_LEN: assert property (@(posedge hclk) disable iff (!hresetn)
    $rose(ssel_n_q) |-> edges_q == 6'(sul_pkg::FRAME_BITS))
    else $error("frame has the wrong number of clocks");
  AST_SCLK_IDLE: assert property (@(posedge hclk) disable iff (!hresetn)
    ssel_n_q |-> !sclk_q) else $error("serial clock moves while deselected");
  AST_MOSI_STABLE: assert property (@(posedge hclk) disable iff (!hresetn)
    sclk_q && $past(sclk_q) |-> $stable(mosi_q)) else $error("data changed while clock high");
  AST_RMW_KEEP: assert property (@(posedge hclk) disable iff (!hresetn)
    $rose(state_q == ST_MOD) |-> ((rmw_q ^ rx_q) & ~ent.mask) == 16'h0000)
    else $error("read-modify-write changed other bits");
  AST_RMW_WRITE: assert property (@(posedge hclk) disable iff (!hresetn)
    s_read_done |-> ##1 (xfer_go && xfer_frame.wr && xfer_frame.addr == ent.addr))
    else $error("read-modify-write did not write back");
  AST_SEQ_LAST: assert property (@(posedge hclk) disable iff (!hresetn)
    $rose(done_flag_q) |-> ent.addr == sul_pkg::SNS_SEQ_MODE && rmw_q[0])
    else $error("program did not end by enabling sequencer");
  AST_DONE_STEP: assert property (@(posedge hclk) disable iff (!hresetn)
    $rose(done_flag_q) |-> step_q == sul_pkg::N_STEPS - 5'h01)
    else $error("program ended before its last step");
  AST_STEP_ORDER: assert property (@(posedge hclk) disable iff (!hresetn)
    (step_q != $past(step_q)) && step_q != 5'h00
    |-> $past(spi_done_q) && $past(state_q == ST_WR))
    else $error("step advanced before write finished");
  AST_DEPTH: assert property (@(posedge hclk) disable iff (!hresetn)
    (state_q == ST_MOD && ent.addr == sul_pkg::SNS_DEPTH) |-> xfer_frame.data[13] == depth8_q)
    else $error("depth bit wrong");
  AST_VARIANT: assert property (@(posedge hclk) disable iff (!hresetn)
    (xfer_go && xfer_frame.addr == sul_pkg::SNS_VARIANT) |->
    xfer_frame.data == {15'h0000, color_q})
    else $error("variant value wrong");
endmodule

/* File: sul_sensor_model.sv */
// Behavioural sensor on the far side of the serial link: register file and power states.
`timescale 1ns/1ps
module sul_sensor_model (
  input wire logic hclk,
  input wire logic sensor_clk_en,
  input wire logic sensor_rst_n,
  input wire logic spi_sclk,
  input wire logic spi_mosi,
  input wire logic spi_ssel_n,
  output logic spi_miso
);
  logic [15:0] regs [0:511];
  logic [25:0] sh;
  logic [15:0] tx;
  logic [8:0] log_a [$];
  logic [15:0] log_d [$];
  int nbits;
  int state;
  int refused;
  int rel_cnt;
  bit clk_ok;
  bit seen;
  // Set only while a frame is open, so the select settling at reset is not taken as a frame.
  bit framing;
  time t_rel;
  time t_first;
  // Non-zero defaults at 129 and 192 expose a read-modify-write that drops other bits.
  task automatic hard_reset();
    foreach (regs[i]) regs[i] = 16'h0000;
    regs[129] = 16'h0050;
    regs[192] = 16'h0082;
    state = 0;
    seen = 1'b0;
    log_a.delete();
    log_d.delete();
  endtask
  task automatic apply(input logic [8:0] a, input logic [15:0] d);
    if (!sensor_clk_en || (state == 0 && a >= 9'h028)) begin
      refused++;
    end else begin
      regs[a] = d;
      log_a.push_back(a);
      log_d.push_back(d);
      if (a == 9'h022 && d[0] && state == 0) state = 1;
      if (a == 9'h1c0 && state == 1) state = 2;
      if (a == 9'h070 && d == 16'h0007 && state == 2) state = 3;
      if (a == 9'h0c0 && state >= 3) state = d[0] ? 4 : 3;
    end
  endtask
  initial begin
    spi_miso = 1'b0;
    refused = 0;
    rel_cnt = 0;
    hard_reset();
  end
  always @(negedge sensor_rst_n) hard_reset();
  always @(posedge sensor_rst_n) begin
    rel_cnt++;
    clk_ok = sensor_clk_en;
    t_rel = $time;
  end
  always @(negedge spi_ssel_n) begin
    nbits = 0;
    framing = 1'b1;
    if (!seen) t_first = $time;
    seen = 1'b1;
  end
  always @(posedge spi_sclk) if (!spi_ssel_n) begin
    sh = {sh[24:0], spi_mosi};
    nbits++;
  end
  always @(negedge spi_sclk) if (!spi_ssel_n) begin
    if (nbits == 10) tx = regs[sh[9:1]];
    if (nbits >= 10) begin
      spi_miso <= tx[15];
      tx = {tx[14:0], 1'h0};
    end
  end
  // A deselected data line shows no stale bit: it toggles every cycle.
  always @(posedge hclk) if (spi_ssel_n) spi_miso <= ~spi_miso;
  always @(posedge spi_ssel_n) if (framing) begin
    framing = 1'b0;
    if (nbits != 26) refused++;
    else if (sh[16]) apply(sh[25:17], sh[15:0]);
  end
endmodule

/* File: test_sensor_startup_upload_sequence.sv */
// Self-checking bench for the start-up upload controller with a sensor model.
`timescale 1ns/1ps
module test_sensor_startup_upload_sequence;
  logic hclk = 1'h0;
  logic hresetn;
  logic hsel = 1'h0;
  logic hwrite = 1'h0;
  logic [31:0] haddr = 32'h0;
  logic [31:0] hwdata = 32'h0;
  logic [1:0] htrans = 2'h0;
  logic [2:0] hsize = 3'h2;
  logic hreadyout, hresp, clk_en, rst_n, sclk, mosi, ssel_n, miso;
  logic [31:0] hrdata;
  int errors = 0;
  int checks = 0;
  int cyc = 0;
  logic [8:0] ea [20] = '{9'h002, 9'h020, 9'h022, 9'h041, 9'h042, 9'h043, 9'h044, 9'h080,
    9'h0cc, 9'h0e0, 9'h0e1, 9'h081, 9'h1bf, 9'h1c0, 9'h020, 9'h040, 9'h028, 9'h030,
    9'h070, 9'h0c0};
  logic [15:0] ed [20] = '{16'h0, 16'h2002, 16'h0001, 16'h008b, 16'h53c6, 16'h0844,
    16'h0086, 16'h4520, 16'h09e5, 16'h3e04, 16'h6733, 16'h0, 16'h0bf1, 16'h0bc3,
    16'h2003, 16'h0001, 16'h0003, 16'h0001, 16'h0007, 16'h0083};
  always #50 hclk = ~hclk;
  sul_ctrl uut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
    .hreadyout(hreadyout), .hrdata(hrdata), .hresp(hresp), .sensor_clk_en(clk_en),
    .sensor_rst_n(rst_n), .spi_sclk(sclk), .spi_mosi(mosi), .spi_ssel_n(ssel_n),
    .spi_miso(miso));
  sul_sensor_model peer (.hclk(hclk), .sensor_clk_en(clk_en), .sensor_rst_n(rst_n),
    .spi_sclk(sclk), .spi_mosi(mosi), .spi_ssel_n(ssel_n), .spi_miso(miso));
  task automatic tally_and_finish();
    $display("checks %0d errors %0d", checks, errors);
    if (errors == 0 && checks > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask
  always @(posedge hclk) begin
    cyc++;
    if (cyc == 40000) begin
      errors++;
      $display("[FAIL] %0t timeout", $time);
      tally_and_finish();
    end
  end
  task automatic check_word(input logic [31:0] got, input logic [31:0] exp, input string w);
    checks++;
    if (got !== exp) begin
      errors++;
      $display("[FAIL] %0t %s got %h exp %h", $time, w, got, exp);
    end
  endtask
  task automatic check_bit(input logic got, input logic exp, input string w);
    check_word({31'h0, got}, {31'h0, exp}, w);
  endtask
  task automatic ahb(input logic [7:0] a, input logic w, input logic [31:0] wd,
    output logic [31:0] rd);
    hsel <= 1'h1;
    haddr <= {24'h0, a};
    htrans <= 2'h2;
    hwrite <= w;
    do @(posedge hclk); while (hreadyout !== 1'h1);
    htrans <= 2'h0;
    hsel <= 1'h0;
    hwdata <= wd;
    do @(posedge hclk); while (hreadyout !== 1'h1);
    rd = hrdata;
  endtask
  task automatic test_reset();
    logic [31:0] rd;
    check_bit(clk_en, 1'h0, "clk_en idle");
    check_bit(rst_n, 1'h0, "rst_n idle");
    check_bit(ssel_n, 1'h1, "ssel_n idle");
    check_bit(sclk, 1'h0, "sclk idle");
    check_bit(hresp, 1'h0, "hresp");
    ahb(8'h20, 1'h1, 32'hffff_ffff, rd);
    ahb(8'h20, 1'h0, 32'h0, rd);
    check_word(rd, 32'h0, "unmapped read");
    ahb(sul_pkg::REG_STATUS, 1'h0, 32'h0, rd);
    check_word(rd, 32'h0, "status idle");
    $display("test_reset done");
  endtask
  // Runs the whole program and judges the sensor's view of it.
  task automatic run_program(input logic color, input logic d8);
    logic [31:0] rd;
    int rel0;
    rel0 = peer.rel_cnt;
    ahb(sul_pkg::REG_CTRL, 1'h1, {29'h0, d8, color, 1'h1}, rd);
    repeat (40) @(posedge hclk);
    // A second start while busy must not restart the sensor.
    ahb(sul_pkg::REG_CTRL, 1'h1, {29'h0, d8, color, 1'h1}, rd);
    rd = 32'h0;
    for (int i = 0; i < 300 && rd[1] !== 1'h1; i++) begin
      repeat (50) @(posedge hclk);
      ahb(sul_pkg::REG_STATUS, 1'h0, 32'h0, rd);
    end
    check_word({26'h0, rd[5:0]}, 32'h32, "status done");
    check_word(peer.rel_cnt - rel0, 32'h1, "one reset release");
    check_bit(peer.clk_ok, 1'h1, "clock before release");
    check_bit(peer.t_first - peer.t_rel >= 10000, 1'h1, "first write delay");
    check_word(peer.refused, 32'h0, "refused frames");
    check_word(peer.state, 32'h4, "sensor running");
    check_word(peer.log_a.size(), 32'h14, "write count");
    ed[0] = {15'h0, color};
    ed[11] = d8 ? 16'h2050 : 16'h0050;
    for (int i = 0; i < 20 && i < peer.log_a.size(); i++) begin
      check_word({23'h0, peer.log_a[i]}, {23'h0, ea[i]}, "write address");
      check_word({16'h0, peer.log_d[i]}, {16'h0, ed[i]}, "write data");
    end
    ahb(sul_pkg::REG_RDATA, 1'h0, 32'h0, rd);
    check_word({16'h0, rd[15:0]}, 32'h0082, "rmw read data");
    check_bit(clk_en & rst_n, 1'h1, "sensor left powered");
    $display("run_program color %0d depth8 %0d done", color, d8);
  endtask
  initial begin
    // Driven at time zero so that the asynchronous reset sees a real falling edge.
    hresetn <= 1'h0;
    repeat (8) @(posedge hclk);
    hresetn <= 1'h1;
    @(posedge hclk);
    test_reset();
    run_program(1'h1, 1'h1);
    run_program(1'h0, 1'h0);
    tally_and_finish();
  end
endmodule
